// file: core/lct_consts.vh
// Register map, field positions, reset values and timing counts of the capture engine.
`ifndef LCT_CONSTS_VH
`define LCT_CONSTS_VH
`define LCT_REG_CTRL       16'h0000
`define LCT_REG_STATUS     16'h0004
`define LCT_REG_PERIOD     16'h0008
`define LCT_REG_DELAY      16'h000c
`define LCT_REG_GRP0       16'h0010
`define LCT_REG_LVL0       16'h0020
`define LCT_LVL_STRIDE     16'h0010
`define LCT_MEM_SRC0       16'h1000
`define LCT_MEM_REF_LO     16'h4000
`define LCT_MEM_REF_HI     16'h5000
`define LCT_CTRL_ARM       0
`define LCT_CTRL_STOP      1
`define LCT_CTRL_ORG_LO    2
`define LCT_CTRL_RESTART   5
`define LCT_CTRL_ERRCLR    6
`define LCT_GRP_FALL       2
`define LCT_GRP_QLOW       3
`define LCT_GRP_QEN        4
`define LCT_GRP_GLITCH     5
`define LCT_LVL_NEG        8
`define LCT_ORG_RST        3'h0
`define LCT_PERIOD_RST     26'h0000007
`define LCT_DELAY_RST      12'h000
`define LCT_PASS_RST       8'h01
`define LCT_CLK_MHZ        125
`define LCT_INT_MIN_NS     20
`define LCT_INT_SLOW_NS    40
`define LCT_INT_MAX_NS     500000000
`define LCT_INT_MIN_CYC    ((`LCT_INT_MIN_NS * `LCT_CLK_MHZ + 999) / 1000)
`define LCT_INT_SLOW_CYC   ((`LCT_INT_SLOW_NS * `LCT_CLK_MHZ + 999) / 1000)
`define LCT_INT_MAX_CYC    ((`LCT_INT_MAX_NS / 1000) * `LCT_CLK_MHZ)
`define LCT_DELAY_MAX      4095
`endif

// file: core/lct_engine.v
// Acquisition and sequential trigger engine of a 48-channel logic analyzer.
// Function
// - Trigger completes only after four event levels (three when the fourth is the restart condition) are satisfied in order.
// - Each level advances on word seen, or on word not seen when negated.
// - Each level word is 48 bits with a per-bit care mask.
// - Each level has its own pass counter, programmable 1 to 255.
// - Active level's current pass count is readable while the sequence runs.
// - Fourth level may act as restart condition instead of a step.
// - Post-trigger delay of 0 to 4095 sample ticks expires before freezing.
// - Output A goes high whenever any programmed trigger word is detected.
// - Output B goes high once the whole trigger sequence has finished.
// - Recording runs continuously until the post-trigger delay expires, then memory freezes.
// - Glitch mode stores inverse of previous sample on even nonzero transitions.
// - Recording memory is three blocks of 16 channels by 1024 words.
// - Blocks arrange into five recording organizations by configuration.
// - Reference memory of 48 bits by 1024 words is provided.
// - Each 16-channel group selects internal or one of three external clocks.
// - Each group samples its external clock on a programmable edge.
// - External clock edges are ignored while the qualifier is inactive.
// - Internal sample period is programmable from 24 ns (3 clocks) to 500 ms.
// - Fastest internal rate is refused outside organizations 3 and 4.
`timescale 1ns/10ps
`include "lct_consts.vh"
module lct_engine (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire [47:0] probe_data,
   input  wire [2:0]  ext_clk,
   input  wire [2:0]  ext_qual,
   output reg         trig_out_a,
   output wire        trig_out_b
);
   localparam ST_IDLE  = 4'b0001;
   localparam ST_SEQ   = 4'b0010;
   localparam ST_DELAY = 4'b0100;
   localparam ST_DONE  = 4'b1000;

   // Every pin crosses two flip-flops; the third stage only serves edge detection.
   reg  [47:0] d_s1, d_s2, d_s3;
   reg  [2:0]  c_s1, c_s2, c_s3;
   reg  [2:0]  q_s1, q_s2;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         d_s1 <= 48'h0; d_s2 <= 48'h0; d_s3 <= 48'h0;
         c_s1 <= 3'h0;  c_s2 <= 3'h0;  c_s3 <= 3'h0;
         q_s1 <= 3'h0;  q_s2 <= 3'h0;
      end else begin
         d_s1 <= probe_data; d_s2 <= d_s1; d_s3 <= d_s2;
         c_s1 <= ext_clk;    c_s2 <= c_s1; c_s3 <= c_s2;
         q_s1 <= ext_qual;   q_s2 <= q_s1;
      end
   end

   // Configuration registers.
   reg  [2:0]  org;
   reg         restart_en;
   reg  [25:0] period;
   reg  [11:0] delay_cfg;
   reg  [5:0]  grp_cfg [0:2];
   reg  [47:0] lvl_word [0:3];
   reg  [47:0] lvl_mask [0:3];
   reg  [7:0]  lvl_pass [0:3];
   reg         lvl_neg  [0:3];
   reg         rate_err;
   reg         arm_pulse, stop_pulse;

   // Internal sample clock divider.
   reg  [25:0] icnt;
   wire        tick_int = (icnt >= period - 26'h1);
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) icnt <= 26'h0;
      else if (tick_int) icnt <= 26'h0;
      else icnt <= icnt + 26'h1;
   end

   // Per-group clock selection, edge, qualifier and glitch latch.
   wire [2:0]  tick;
   wire [15:0] sval [0:2];
   reg  [15:0] samp [0:2];
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : grp
         wire [1:0]  sel  = grp_cfg[g][1:0];
         wire [1:0]  xi   = sel - 2'h1;
         wire        ec   = c_s2[xi];
         wire        ep   = c_s3[xi];
         wire        edge_hit = grp_cfg[g][`LCT_GRP_FALL] ? (ep & ~ec) : (~ep & ec);
         wire        q_ok = ~grp_cfg[g][`LCT_GRP_QEN] |
                            (q_s2[xi] ^ grp_cfg[g][`LCT_GRP_QLOW]);
         assign tick[g] = (sel == 2'h0) ? tick_int : (edge_hit & q_ok);
         reg  [15:0] tog_any, tog_par;
         wire [15:0] chg = d_s2[16*g+15:16*g] ^ d_s3[16*g+15:16*g];
         wire [15:0] any_n = tog_any | chg;
         wire [15:0] par_n = tog_par ^ chg;
         // Even and nonzero transition count since the last tick marks a glitch.
         wire [15:0] glitch = grp_cfg[g][`LCT_GRP_GLITCH] ? (any_n & ~par_n) : 16'h0;
         assign sval[g] = (d_s2[16*g+15:16*g] & ~glitch) | (~samp[g] & glitch);
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               tog_any <= 16'h0;
               tog_par <= 16'h0;
               samp[g] <= 16'h0;
            end else if (tick[g]) begin
               tog_any <= 16'h0;
               tog_par <= 16'h0;
               samp[g] <= sval[g];
            end else begin
               tog_any <= any_n;
               tog_par <= par_n;
            end
         end
      end
   endgenerate

   // Trigger evaluation on the group-0 tick against group 0's current sample and the last latched samples of groups 1 and 2.
   reg  [3:0]  state;
   reg  [1:0]  level;
   reg  [7:0]  pcnt [0:3];
   reg  [11:0] dcnt;
   wire [47:0] cur = {samp[2], samp[1], sval[0]};
   wire [3:0]  hit;
   wire [3:0]  used;
   generate
      for (g = 0; g < 4; g = g + 1) begin : lvm
         assign hit[g] = (((cur ^ lvl_word[g]) & lvl_mask[g]) == 48'h0);
         // A level with an all-clear mask matches everything, so it must not drive output A.
         assign used[g] = |lvl_mask[g];
      end
   endgenerate
   wire        lcond = hit[level] ^ lvl_neg[level];
   wire [1:0]  last  = restart_en ? 2'h2 : 2'h3;
   wire        do_restart = restart_en & hit[3] & ~lvl_neg[3] & (state == ST_SEQ);
   wire        tick_t = tick[0];
   wire        recording = (state == ST_SEQ) | (state == ST_DELAY);
   assign trig_out_b = (state == ST_DELAY) | (state == ST_DONE);

   integer i;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         level <= 2'h0;
         dcnt  <= 12'h0;
         trig_out_a <= 1'b0;
         for (i = 0; i < 4; i = i + 1) pcnt[i] <= `LCT_PASS_RST;
      end else begin
         if (tick_t) trig_out_a <= |(hit & used);
         if (arm_pulse | (tick_t & do_restart)) begin
            state <= arm_pulse ? ST_SEQ : state;
            level <= 2'h0;
            for (i = 0; i < 4; i = i + 1)
               pcnt[i] <= (lvl_pass[i] == 8'h0) ? 8'h1 : lvl_pass[i];
         end else if (stop_pulse) begin
            state <= ST_DONE;
         end else begin
            case (state)
               ST_IDLE: state <= ST_IDLE;
               ST_SEQ: if (tick_t & lcond) begin
                  pcnt[level] <= pcnt[level] - 8'h1;
                  if (pcnt[level] == 8'h1) begin
                     if (level == last) begin
                        state <= ST_DELAY;
                        dcnt  <= delay_cfg;
                     end else begin
                        level <= level + 2'h1;
                     end
                  end
               end
               ST_DELAY: if (dcnt == 12'h0) state <= ST_DONE;
                  else if (tick_t) dcnt <= dcnt - 12'h1;
               ST_DONE: state <= ST_DONE;
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Recording memory: three 16 x 1024 blocks in one of five organizations.
   //   0: three independent groups   1: 48 wide on group-0 clock
   //   2: groups 0,1 on group-0 clock, group 2 alone
   //   3: group 0 chained through all blocks (3072 deep)
   //   4: group 0 chained through blocks 0,1, group 2 alone
   reg  [15:0] mem0 [0:1023];
   reg  [15:0] mem1 [0:1023];
   reg  [15:0] mem2 [0:1023];
   reg  [9:0]  wp [0:2];
   reg  [1:0]  cp;
   reg  [11:0] trig_addr;
   reg  [2:0]  bwe;
   reg  [15:0] bdat [0:2];
   integer     j, k, m;
   wire        chain3 = (org == 3'h3);
   wire        chain2 = (org == 3'h4);
   always @* begin
      for (j = 0; j < 3; j = j + 1) begin
         bdat[j] = sval[j];
         bwe[j]  = tick[j];
      end
      case (org)
         3'h1: begin
            bwe = {3{tick[0]}};
         end
         3'h2: begin
            bwe[1] = tick[0];
         end
         3'h3: begin
            bwe = {cp == 2'h2, cp == 2'h1, cp == 2'h0} & {3{tick[0]}};
            bdat[1] = sval[0];
            bdat[2] = sval[0];
         end
         3'h4: begin
            bwe[1:0] = {cp == 2'h1, cp == 2'h0} & {2{tick[0]}};
            bdat[1] = sval[0];
         end
         default: bwe = tick;
      endcase
      bwe = bwe & {3{recording}};
   end
   wire [1:0]  cp_top = chain3 ? 2'h2 : 2'h1;
   always @(posedge clk_sys) begin
      if (bwe[0]) mem0[wp[0]] <= bdat[0];
      if (bwe[1]) mem1[wp[1]] <= bdat[1];
      if (bwe[2]) mem2[wp[2]] <= bdat[2];
   end
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < 3; k = k + 1) wp[k] <= 10'h0;
         cp <= 2'h0;
         trig_addr <= 12'h0;
      end else begin
         for (k = 0; k < 3; k = k + 1)
            if (bwe[k]) wp[k] <= wp[k] + 10'h1;
         if ((chain3 | chain2) & bwe[cp] & (wp[cp] == 10'h3ff))
            cp <= (cp == cp_top) ? 2'h0 : cp + 2'h1;
         if ((state == ST_SEQ) & (level == last) & tick_t & lcond & (pcnt[level] == 8'h1))
            trig_addr <= {cp, wp[0]};
      end
   end

   // Reference memory kept for later comparison against the source memory.
   reg  [47:0] refm [0:1023];

   // AHB-Lite slave: one wait state on every transfer, response always OKAY.
   reg         busy, l_wr;
   reg  [15:0] l_addr;
   assign hreadyout = ~busy;
   assign hresp = 1'b0;
   wire [9:0]  widx = l_addr[11:2];
   wire [1:0]  lsel = l_addr[5:4] - 2'h2;
   wire        is_lvl = (l_addr >= `LCT_REG_LVL0) &&
                        (l_addr < `LCT_REG_LVL0 + 4 * `LCT_LVL_STRIDE);
   wire        is_grp = (l_addr >= `LCT_REG_GRP0) && (l_addr < `LCT_REG_GRP0 + 16'hc);
   wire [1:0]  gsel = l_addr[3:2];
   wire [31:0] pmin_w = (org >= 3'h3) ? `LCT_INT_MIN_CYC : `LCT_INT_SLOW_CYC;
   wire [25:0] pmin = pmin_w[25:0];
   reg  [31:0] rdv;
   always @* begin
      rdv = 32'h0;
      case (l_addr[15:12])
         4'h0: begin
            if (l_addr == `LCT_REG_CTRL)
               rdv = {26'h0, restart_en, org, 2'h0};
            else if (l_addr == `LCT_REG_STATUS)
               rdv = {trig_addr, 1'b0, rate_err, 2'h0, pcnt[level], 2'h0, level, state};
            else if (l_addr == `LCT_REG_PERIOD)
               rdv = {6'h0, period};
            else if (l_addr == `LCT_REG_DELAY)
               rdv = {20'h0, delay_cfg};
            else if (is_grp)
               rdv = {26'h0, grp_cfg[gsel]};
            else if (is_lvl)
               case (l_addr[3:2])
                  2'h0: rdv = lvl_word[lsel][31:0];
                  2'h1: rdv = {16'h0, lvl_word[lsel][47:32]};
                  2'h2: rdv = lvl_mask[lsel][31:0];
                  default: rdv = {lvl_mask[lsel][47:32], 7'h0, lvl_neg[lsel], lvl_pass[lsel]};
               endcase
         end
         4'h1: rdv = {16'h0, mem0[widx]};
         4'h2: rdv = {16'h0, mem1[widx]};
         4'h3: rdv = {16'h0, mem2[widx]};
         4'h4: rdv = refm[widx][31:0];
         4'h5: rdv = {16'h0, refm[widx][47:32]};
         default: rdv = 32'h0;
      endcase
   end
   always @(posedge clk_sys) begin
      if (busy & l_wr & (l_addr[15:12] == 4'h4)) refm[widx][31:0] <= hwdata;
      if (busy & l_wr & (l_addr[15:12] == 4'h5)) refm[widx][47:32] <= hwdata[15:0];
   end
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0; l_wr <= 1'b0; l_addr <= 16'h0; hrdata <= 32'h0;
         org <= `LCT_ORG_RST; restart_en <= 1'b0;
         period <= `LCT_PERIOD_RST; delay_cfg <= `LCT_DELAY_RST;
         rate_err <= 1'b0; arm_pulse <= 1'b0; stop_pulse <= 1'b0;
         for (m = 0; m < 3; m = m + 1) grp_cfg[m] <= 6'h0;
         for (m = 0; m < 4; m = m + 1) begin
            lvl_word[m] <= 48'h0; lvl_mask[m] <= 48'h0;
            lvl_pass[m] <= `LCT_PASS_RST; lvl_neg[m] <= 1'b0;
         end
      end else begin
         arm_pulse  <= 1'b0;
         stop_pulse <= 1'b0;
         if (hsel & htrans[1] & hready & ~busy) begin
            busy <= 1'b1; l_wr <= hwrite; l_addr <= haddr[15:0];
         end else if (busy) begin
            busy <= 1'b0;
            hrdata <= rdv;
            if (l_wr) begin
               if (l_addr == `LCT_REG_CTRL) begin
                  arm_pulse  <= hwdata[`LCT_CTRL_ARM];
                  stop_pulse <= hwdata[`LCT_CTRL_STOP];
                  org <= (hwdata[4:2] > 3'h4) ? 3'h4 : hwdata[4:2];
                  restart_en <= hwdata[`LCT_CTRL_RESTART];
                  if (hwdata[`LCT_CTRL_ERRCLR]) rate_err <= 1'b0;
               end else if (l_addr == `LCT_REG_PERIOD) begin
                  // A period outside the allowed range is refused and flagged.
                  if ((hwdata[25:0] < pmin) || (hwdata[31:0] > `LCT_INT_MAX_CYC))
                     rate_err <= 1'b1;
                  else
                     period <= hwdata[25:0];
               end else if (l_addr == `LCT_REG_DELAY)
                  delay_cfg <= hwdata[11:0];
               else if (is_grp)
                  grp_cfg[gsel] <= hwdata[5:0];
               else if (is_lvl)
                  case (l_addr[3:2])
                     2'h0: lvl_word[lsel][31:0] <= hwdata;
                     2'h1: lvl_word[lsel][47:32] <= hwdata[15:0];
                     2'h2: lvl_mask[lsel][31:0] <= hwdata;
                     default: begin
                        lvl_mask[lsel][47:32] <= hwdata[31:16];
                        lvl_neg[lsel]  <= hwdata[`LCT_LVL_NEG];
                        lvl_pass[lsel] <= hwdata[7:0];
                     end
                  endcase
            end
         end
      end
   end
endmodule // lct_engine

// file: verification/lct_far_model.sv
// Far-side model: probed data pins, external clocks and their qualifiers.
`timescale 1ns/10ps
module lct_far_model (
   input  wire logic [47:0] word,
   input  wire logic        run,
   input  wire logic [2:0]  qual,
   output logic      [47:0] probe_data,
   output logic      [2:0]  ext_clk,
   output wire logic [2:0]  ext_qual
);
   initial ext_clk = 3'h0;
   initial probe_data = 48'h0;
   // An 80 ns period stays under the 25 MHz ceiling; the clock stands low between frames.
   always begin
      #40;
      ext_clk[0] = run ? ~ext_clk[0] : 1'b0;
   end
   // Data only moves while the clock is low so setup and hold around the rising edge are kept.
   always @(word or negedge ext_clk[0]) begin
      if (!ext_clk[0]) probe_data = word;
   end
   assign ext_qual = qual;
endmodule // lct_far_model

// file: verification/lct_engine_monitor.sv
// Port-level checker of the capture engine's bus and trigger output B.
`timescale 1ns/10ps
module lct_engine_monitor (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [47:0] probe_data,
   input wire logic [2:0]  ext_clk,
   input wire logic [2:0]  ext_qual,
   input wire logic        trig_out_a,
   input wire logic        trig_out_b
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire take = hsel && htrans[1] && hready && hreadyout;
   a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
   a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
      else $error("transfer did not take exactly one wait state");
   a_no_long_wait: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
   a_reset_quiet: assert property ($rose(rst_n) |-> hreadyout && !trig_out_b && hrdata == 32'h0)
      else $error("outputs wrong after reset");
   a_b_holds: assert property (trig_out_b && $past(hreadyout) |=> trig_out_b)
      else $error("output B dropped without a write");
   a_b_falls_write: assert property ($fell(trig_out_b) |-> $past(!hreadyout, 2) && $past(hwrite, 3))
      else $error("output B fell outside a write");
   a_rdata_stands: assert property (!$stable(hrdata) |-> $past(!hreadyout))
      else $error("read data moved outside a read");
   a_ready_idle: assert property (!take && hreadyout |=> hreadyout)
      else $error("wait state without a transfer");
endmodule // lct_engine_monitor

// file: verification/lct_engine_tb_top.sv
// Self-checking testbench of the capture engine with its far-side model.
`timescale 1ns/10ps
module lct_engine_tb_top;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [47:0] word = 48'h0;
   logic        run = 1'b0;
   logic [2:0]  qual = 3'h0;
   wire         hreadyout, hresp, trig_out_a, trig_out_b;
   wire  [31:0] hrdata;
   wire  [47:0] probe_data;
   wire  [2:0]  ext_clk, ext_qual;
   integer      bad_count = 0;
   integer      tests_run = 0;
   always #4 clk_sys = ~clk_sys;
   lct_engine dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .probe_data(probe_data),
      .ext_clk(ext_clk), .ext_qual(ext_qual), .trig_out_a(trig_out_a), .trig_out_b(trig_out_b));
   lct_far_model far (.word(word), .run(run), .qual(qual), .probe_data(probe_data),
      .ext_clk(ext_clk), .ext_qual(ext_qual));
   task give_verdict;
      $display("tests %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   // Ready is looked at before the edge, so the slave's own update at that edge cannot race.
   task wait_rdy;
      @(negedge clk_sys);
      while (hreadyout !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
   endtask
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask
   task rchk(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   task lvl(input logic [31:0] l, input logic [15:0] w, input logic [7:0] p, input logic ng);
      bus(1'b1, 32'h20 + 32'h10 * l, {16'h0, w});
      bus(1'b1, 32'h24 + 32'h10 * l, 32'h0);
      bus(1'b1, 32'h28 + 32'h10 * l, 32'h0000ffff);
      bus(1'b1, 32'h2c + 32'h10 * l, {23'h0, ng, p});
   endtask
   task step(input logic [15:0] w, input integer n, input string nm, input logic [31:0] e);
      word <= {32'h0, w};
      idle(n);
      rchk(nm, 32'h4, 32'hff3f, e);
   endtask
   task t_regs;
      rchk("period", 32'h8, 32'h03ffffff, 32'h7);
      rchk("delay", 32'hc, 32'hfff, 32'h0);
      rchk("idle", 32'h4, 32'hf, 32'h1);
      rchk("unmapped", 32'hf00, 32'hffffffff, 32'h0);
      bus(1'b1, 32'h4014, 32'hc3a55a3c);
      bus(1'b1, 32'h5014, 32'h00009e61);
      rchk("ref lo", 32'h4014, 32'hffffffff, 32'hc3a55a3c);
      rchk("ref hi", 32'h5014, 32'hffff, 32'h9e61);
      bus(1'b1, 32'h8, 32'h3);
      rchk("fast refused", 32'h8, 32'h03ffffff, 32'h7);
      rchk("rate err", 32'h4, 32'h40000, 32'h40000);
      bus(1'b1, 32'h0, 32'h40);
      rchk("err clear", 32'h4, 32'h40000, 32'h0);
      bus(1'b1, 32'h8, 32'h03b9aca1);
      rchk("slow refused", 32'h8, 32'h03ffffff, 32'h7);
      bus(1'b1, 32'h0, 32'h0c);
      bus(1'b1, 32'h8, 32'h3);
      rchk("fast taken", 32'h8, 32'h03ffffff, 32'h3);
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b1, 32'h8, 32'h8);
      $display("test regs done");
   endtask
   task t_seq;
      lvl(0, 16'h1, 8'd3, 1'b0);
      lvl(1, 16'h2, 8'd2, 1'b0);
      lvl(2, 16'h55, 8'd1, 1'b1);
      lvl(3, 16'h4, 8'd1, 1'b0);
      bus(1'b1, 32'hc, 32'd20);
      bus(1'b1, 32'h0, 32'h1);
      step(16'h0, 40, "wait l0", 32'h0302);
      chk("out a low", 32'h0, {31'h0, trig_out_a});
      step(16'h1, 60, "l0 passed", 32'h0212);
      chk("out a", 32'h1, {31'h0, trig_out_a});
      step(16'h2, 60, "negated l2", 32'h0132);
      step(16'h4, 30, "delay", 32'h0034);
      chk("out b", 32'h1, {31'h0, trig_out_b});
      idle(200);
      rchk("done", 32'h4, 32'hf, 32'h8);
      $display("test sequence done");
   endtask
   task t_restart;
      word <= 48'h0;
      bus(1'b1, 32'h0, 32'h21);
      idle(1);
      chk("b after arm", 32'h0, {31'h0, trig_out_b});
      step(16'h1, 60, "rs l1", 32'h0212);
      step(16'h4, 30, "restart", 32'h0302);
      $display("test restart done");
   endtask
   task t_ext;
      word <= 48'h0;
      bus(1'b1, 32'h10, 32'h11);
      bus(1'b1, 32'h0, 32'h1);
      run <= 1'b1;
      step(16'h1, 60, "qual off", 32'h0302);
      qual <= 3'h1;
      step(16'h1, 120, "qual on", 32'h0212);
      run <= 1'b0;
      $display("test external clock done");
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs;
      t_seq;
      t_restart;
      t_ext;
      give_verdict;
   end
   initial begin
      #200000;
      bad_count++;
      give_verdict;
   end
endmodule // lct_engine_tb_top
bind lct_engine lct_engine_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .probe_data(probe_data), .ext_clk(ext_clk), .ext_qual(ext_qual),
   .trig_out_a(trig_out_a), .trig_out_b(trig_out_b));
